// *** ilsm_params.svh ***
`ifndef ILSM_PARAMS_SVH
`define ILSM_PARAMS_SVH
// Source vector layout.
`define ILSM_NSRC 25
`define ILSM_SEL_W 5
`define ILSM_SRC_IN0 0
`define ILSM_SRC_RXD 4
`define ILSM_SRC_TX1 5
`define ILSM_SRC_PG0 6
`define ILSM_SRC_PG1 7
`define ILSM_SRC_DUTYA 8
`define ILSM_SRC_DUTYB 9
`define ILSM_SRC_EXPOSE 10
`define ILSM_SRC_READOUT 11
`define ILSM_SRC_SEQPA 12
`define ILSM_SRC_DUTYC 13
`define ILSM_SRC_DUTYD 14
`define ILSM_SRC_SEQRUN 15
`define ILSM_SRC_DEBOUNCE 16
`define ILSM_SRC_PRESCALE 17
`define ILSM_SRC_SEQPB 18
`define ILSM_SRC_LOGIC 19
`define ILSM_SRC_PG2 20
`define ILSM_SRC_PG3 21
`define ILSM_SRC_RXD2 22
`define ILSM_SRC_TRIGFB 23
`define ILSM_SRC_TX2 24
// Destination vector layout.
`define ILSM_NDST 18
`define ILSM_DST_OD0 0
`define ILSM_DST_TXD 4
`define ILSM_DST_RX1 5
`define ILSM_DST_TRIG 6
`define ILSM_DST_SEQ 7
`define ILSM_DST_DEB 8
`define ILSM_DST_PRE 9
`define ILSM_DST_LOGA 10
`define ILSM_DST_LOGB 11
`define ILSM_DST_MFT 12
`define ILSM_DST_PG0 13
`define ILSM_DST_RX2 17
// Timing quantum and the sizes of the Boolean operation field.
`define ILSM_QUANTUM_PS 15000
`define ILSM_OP_W 2
`define ILSM_SEL_NONE 5'h1f
`endif

// *** ilsm_pkg.sv ***
package ilsm_pkg;
  typedef enum logic [1:0] {ILSM_OP_AND, ILSM_OP_OR, ILSM_OP_XOR, ILSM_OP_NAND} ilsm_op_t;
  typedef enum logic [1:0] {ILSM_NV_IDLE, ILSM_NV_SAVE, ILSM_NV_LOAD} ilsm_nv_t;
endpackage : ilsm_pkg

// *** ilsm_line_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ilsm_line_if #(parameter int NSRC = 25);
  logic [NSRC-1:0] src;
  logic [4:0]      sel;
  logic            inv;
  logic            force_hi;
  logic            y;
  modport mat (input src, sel, inv, force_hi, output y);
  modport top (output src, sel, inv, force_hi, input y);
endinterface : ilsm_line_if
`default_nettype wire

// *** ilsm_line_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ilsm_params.svh"
module ilsm_line_cell
(
  input  wire logic   clk,
  input  wire logic   rst,
  ilsm_line_if.mat    ln
);
  import ilsm_pkg::*;
  logic y_q;
  wire  valid_sel = ln.sel < 5'(`ILSM_NSRC);
  wire  picked    = valid_sel ? ln.src[ln.sel] : 1'b0;
  wire  forced    = ln.force_hi | picked;
  wire  y_d       = ln.inv ? ~forced : forced;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      y_q <= 1'b0;
    else
      y_q <= y_d;
  end
  assign ln.y = y_q;

  // Checked against the raw source bit so that a wrong pick or a lost inverter shows up.
  AST_LINE_OUT: assert property (@(posedge clk) disable iff (rst)
    (valid_sel && !ln.force_hi) |=> ln.y == ($past(ln.inv) ^ $past(ln.src[ln.sel])))
    else $error("Line output does not follow its selection.");
  AST_FORCE_INV: assert property (@(posedge clk) disable iff (rst)
    (ln.force_hi && ln.inv) |=> !ln.y)
    else $error("Forced inverted line is not low.");
  AST_FORCE_HI: assert property (@(posedge clk) disable iff (rst)
    (ln.force_hi && !ln.inv) |=> ln.y)
    else $error("Forced line is not high.");
  AST_BAD_SEL: assert property (@(posedge clk) disable iff (rst)
    (!valid_sel && !ln.force_hi && !ln.inv) |=> !ln.y)
    else $error("Out of range selection drives high.");
endmodule : ilsm_line_cell
`default_nettype wire

// *** io_line_switch_matrix.sv ***
// Notes on behaviour
// - Any input, output or module connection routes to any destination by software.
// - Two routed signals combine by a Boolean op into a new source.
// - Source entries 0 to 3 carry the four trigger input pins.
// - Source entries 6, 7, 20, 21 carry pulse generators 0 to 3.
// - Sequencer feeds 8, 9, 13, 14 duty, 12 pulse, 18 mask, 15 running.
// - Entry 16 debounce, 17 prescaler, 19 Boolean combiner result.
// - 25 sources: 10 expose, 11 readout, 23 feedback, serial rx/tx entries.
// - Debounced input is selectable as source for a following module.
// - Strobe and trigger may go to any physical line.
// - Current routing can be saved to nonvolatile memory.
// - Factory default routing can be restored internally.
// - Setting changes take effect immediately without commit.
// - Durations are counts of 15 ns system clock periods.
// - Dest 0-3 open drain, 6 trigger, 10-11 logic, 13-16 pulse triggers.
// - Each line has an inverter passing the complement.
// - Force-high drives the line high regardless of source.
// - Force-high with inversion drives the line low.
`timescale 1ns/1ps
`default_nettype none
`include "ilsm_params.svh"
module io_line_switch_matrix
#(
  parameter int NDST = `ILSM_NDST,
  parameter int NSRC = `ILSM_NSRC
)
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [3:0]              trig_pin_in,
  input  wire logic                    serial_rxd_pin,
  input  wire logic                    serial2_rxd_pin,
  input  wire logic                    serial1_tx_src,
  input  wire logic                    serial2_tx_src,
  input  wire logic [3:0]              pulse_gen_out,
  input  wire logic [3:0]              seq_duty_out,
  input  wire logic                    seq_pulse,
  input  wire logic                    seq_mask_pulse,
  input  wire logic                    seq_running,
  input  wire logic                    debounce_out,
  input  wire logic                    prescale_out,
  input  wire logic                    exposing,
  input  wire logic                    reading_out,
  input  wire logic                    trigger_feedback,
  input  wire logic                    cfg_we,
  input  wire logic [4:0]              cfg_line,
  input  wire logic [4:0]              cfg_src,
  input  wire logic                    cfg_inv,
  input  wire logic                    cfg_force_hi,
  input  wire logic                    cfg_op_we,
  input  wire ilsm_pkg::ilsm_op_t      cfg_op,
  input  wire logic                    save_req,
  input  wire logic                    factory_req,
  output var logic                     nv_we,
  output var logic [4:0]               nv_addr,
  output var logic [6:0]               nv_wdata,
  output var logic                     nv_busy,
  output var logic [NDST-1:0]          line_out,
  output var logic [3:0]               od_drive_low,
  output var logic                     logic_result
);
  import ilsm_pkg::*;

  logic [3:0] trig_s1_q, trig_s2_q;
  logic [1:0] rxd_s1_q, rxd_s2_q;
  logic [4:0] sel_q [NDST];
  logic       inv_q [NDST];
  logic       fhi_q [NDST];
  ilsm_op_t   op_q;
  ilsm_nv_t   nv_q;
  logic [4:0] nv_idx_q;
  logic [NSRC-1:0] src_vec;
  logic [NDST-1:0] y_vec;

  // Pins are asynchronous to clk and pass two flip-flops first.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trig_s1_q <= 4'h0;
      trig_s2_q <= 4'h0;
      rxd_s1_q  <= 2'h3;
      rxd_s2_q  <= 2'h3;
    end
    else
    begin
      trig_s1_q <= trig_pin_in;
      trig_s2_q <= trig_s1_q;
      rxd_s1_q  <= {serial2_rxd_pin, serial_rxd_pin};
      rxd_s2_q  <= rxd_s1_q;
    end
  end

  function automatic logic combine(input ilsm_op_t op, input logic a, input logic b);
    unique case (op)
      ILSM_OP_AND:  combine = a & b;
      ILSM_OP_OR:   combine = a | b;
      ILSM_OP_XOR:  combine = a ^ b;
      ILSM_OP_NAND: combine = ~(a & b);
    endcase
  endfunction : combine

  // Combiner result is computed from the registered line outputs and fed back.
  wire logic_d = combine(op_q, y_vec[`ILSM_DST_LOGA], y_vec[`ILSM_DST_LOGB]);

  assign src_vec[`ILSM_SRC_IN0 +: 4]    = trig_s2_q;
  assign src_vec[`ILSM_SRC_RXD]         = rxd_s2_q[0];
  assign src_vec[`ILSM_SRC_TX1]         = serial1_tx_src;
  assign src_vec[`ILSM_SRC_PG0]         = pulse_gen_out[0];
  assign src_vec[`ILSM_SRC_PG1]         = pulse_gen_out[1];
  assign src_vec[`ILSM_SRC_DUTYA]       = seq_duty_out[0];
  assign src_vec[`ILSM_SRC_DUTYB]       = seq_duty_out[1];
  assign src_vec[`ILSM_SRC_EXPOSE]      = exposing;
  assign src_vec[`ILSM_SRC_READOUT]     = reading_out;
  assign src_vec[`ILSM_SRC_SEQPA]       = seq_pulse;
  assign src_vec[`ILSM_SRC_DUTYC]       = seq_duty_out[2];
  assign src_vec[`ILSM_SRC_DUTYD]       = seq_duty_out[3];
  assign src_vec[`ILSM_SRC_SEQRUN]      = seq_running;
  assign src_vec[`ILSM_SRC_DEBOUNCE]    = debounce_out;
  assign src_vec[`ILSM_SRC_PRESCALE]    = prescale_out;
  assign src_vec[`ILSM_SRC_SEQPB]       = seq_mask_pulse;
  assign src_vec[`ILSM_SRC_LOGIC]       = logic_result;
  assign src_vec[`ILSM_SRC_PG2]         = pulse_gen_out[2];
  assign src_vec[`ILSM_SRC_PG3]         = pulse_gen_out[3];
  assign src_vec[`ILSM_SRC_RXD2]        = rxd_s2_q[1];
  assign src_vec[`ILSM_SRC_TRIGFB]      = trigger_feedback;
  assign src_vec[`ILSM_SRC_TX2]         = serial2_tx_src;

  // One cell per destination, each free to pick any source.
  for (genvar i = 0; i < NDST; i++)
  begin : g_line
    ilsm_line_if #(.NSRC(NSRC)) ln ();
    assign ln.src      = src_vec;
    assign ln.sel      = sel_q[i];
    assign ln.inv      = inv_q[i];
    assign ln.force_hi = fhi_q[i];
    assign y_vec[i]    = ln.y;
    ilsm_line_cell u_cell
    (
      .clk (clk),
      .rst (rst),
      .ln  (ln)
    );
  end

  // Factory default: every line unrouted and low.
  wire cfg_hit = cfg_we && (cfg_line < 5'(NDST));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NDST; i++)
      begin
        sel_q[i] <= `ILSM_SEL_NONE;
        inv_q[i] <= 1'b0;
        fhi_q[i] <= 1'b0;
      end
      op_q <= ILSM_OP_AND;
    end
    else if (factory_req)
    begin
      for (int i = 0; i < NDST; i++)
      begin
        sel_q[i] <= `ILSM_SEL_NONE;
        inv_q[i] <= 1'b0;
        fhi_q[i] <= 1'b0;
      end
      op_q <= ILSM_OP_AND;
    end
    else
    begin
      if (cfg_hit)
      begin
        sel_q[cfg_line] <= cfg_src;
        inv_q[cfg_line] <= cfg_inv;
        fhi_q[cfg_line] <= cfg_force_hi;
      end
      if (cfg_op_we)
        op_q <= cfg_op;
    end
  end

  // Save walks all lines out to the nonvolatile store, one word per cycle.
  // The save length is a plain count of system clock periods, one per line plus one closing cycle.
  wire nv_last = nv_idx_q == 5'(NDST - 1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nv_q     <= ILSM_NV_IDLE;
      nv_idx_q <= 5'h0;
      nv_we    <= 1'b0;
      nv_addr  <= 5'h0;
      nv_wdata <= 7'h0;
      nv_busy  <= 1'b0;
    end
    else
    begin
      nv_we <= 1'b0;
      unique case (nv_q)
        ILSM_NV_IDLE:
          if (save_req && !factory_req)
          begin
            nv_q     <= ILSM_NV_SAVE;
            nv_idx_q <= 5'h0;
            nv_busy  <= 1'b1;
          end
        ILSM_NV_SAVE:
        begin
          nv_we    <= 1'b1;
          nv_addr  <= nv_idx_q;
          nv_wdata <= {fhi_q[nv_idx_q], inv_q[nv_idx_q], sel_q[nv_idx_q]};
          nv_idx_q <= nv_idx_q + 5'h1;
          if (nv_last)
            nv_q <= ILSM_NV_LOAD;
        end
        ILSM_NV_LOAD:
        begin
          nv_q    <= ILSM_NV_IDLE;
          nv_busy <= 1'b0;
        end
        default:
          nv_q <= ILSM_NV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      line_out     <= '0;
      od_drive_low <= 4'h0;
      logic_result <= 1'b0;
    end
    else
    begin
      line_out     <= y_vec;
      od_drive_low <= ~y_vec[`ILSM_DST_OD0 +: 4];
      logic_result <= logic_d;
    end
  end

  AST_NV_COUNT: assert property (@(posedge clk) disable iff (rst)
    (nv_q == ILSM_NV_IDLE && save_req && !factory_req) |=> nv_busy [*8])
    else $error("Save ended too early.");
  AST_FACTORY: assert property (@(posedge clk) disable iff (rst)
    factory_req |=> sel_q[0] == `ILSM_SEL_NONE && !fhi_q[0])
    else $error("Factory restore left routing in place.");
  AST_CFG_NOW: assert property (@(posedge clk) disable iff (rst)
    (cfg_we && cfg_line == 5'h0 && !factory_req) |=> sel_q[0] == $past(cfg_src))
    else $error("Setting did not take effect at once.");
  AST_LOGIC: assert property (@(posedge clk) disable iff (rst)
    (op_q == ILSM_OP_XOR) |=>
      logic_result == ($past(y_vec[`ILSM_DST_LOGA]) ^ $past(y_vec[`ILSM_DST_LOGB])))
    else $error("Combiner result wrong.");
  AST_OD: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> od_drive_low[0] == !$past(y_vec[0]))
    else $error("Open drain line wrong.");
  AST_TRIG_PIN: assert property (@(posedge clk) disable iff (rst)
    (sel_q[`ILSM_DST_TRIG] == 5'(`ILSM_SRC_IN0) && !inv_q[`ILSM_DST_TRIG] &&
     !fhi_q[`ILSM_DST_TRIG]) [*4] |-> y_vec[`ILSM_DST_TRIG] == $past(trig_s2_q[0]))
    else $error("Trigger pin not routed.");
  COV_SAVE: cover property (@(posedge clk) nv_we && nv_last);
  COV_FACT: cover property (@(posedge clk) factory_req);
  COV_LOGIC: cover property (@(posedge clk) logic_result);
endmodule : io_line_switch_matrix
`default_nettype wire

// *** ilsm_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Stands in for the camera pins and the internal I/O modules; pat holds one bit per source index.
module ilsm_far_model
(
  input  wire logic [24:0] pat,
  output logic [3:0]       trig_pin_in,
  output logic             serial_rxd_pin,
  output logic             serial2_rxd_pin,
  output logic             serial1_tx_src,
  output logic             serial2_tx_src,
  output logic [3:0]       pulse_gen_out,
  output logic [3:0]       seq_duty_out,
  output logic             seq_pulse,
  output logic             seq_mask_pulse,
  output logic             seq_running,
  output logic             debounce_out,
  output logic             prescale_out,
  output logic             exposing,
  output logic             reading_out,
  output logic             trigger_feedback
);
  assign trig_pin_in      = pat[3:0];
  assign pulse_gen_out    = {pat[21], pat[20], pat[7], pat[6]};
  assign seq_duty_out     = {pat[14], pat[13], pat[9], pat[8]};
  assign seq_pulse        = pat[12];
  assign seq_mask_pulse   = pat[18];
  assign seq_running      = pat[15];
  assign debounce_out     = pat[16];
  assign prescale_out     = pat[17];
  assign exposing         = pat[10];
  assign reading_out      = pat[11];
  assign trigger_feedback = pat[23];
  assign serial_rxd_pin   = pat[4];
  assign serial2_rxd_pin  = pat[22];
  assign serial1_tx_src   = pat[5];
  assign serial2_tx_src   = pat[24];
endmodule : ilsm_far_model
`default_nettype wire

// *** io_line_switch_matrix_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module io_line_switch_matrix_tb_top;
  import ilsm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [24:0] pat = 25'h0;
  logic        cfg_we = 1'b0;
  logic        cfg_inv = 1'b0;
  logic        cfg_fh = 1'b0;
  logic        cfg_op_we = 1'b0;
  logic        save_req = 1'b0;
  logic        factory_req = 1'b0;
  logic [4:0]  cfg_line = 5'h0;
  logic [4:0]  cfg_src = 5'h0;
  ilsm_op_t    cfg_op = ILSM_OP_AND;
  logic [3:0]  trig, pg, duty;
  logic        rxd, rxd2, tx1, tx2, sp, smp, sr, deb, pre, expo, rd, tfb;
  logic        nv_we, nv_busy, logic_result;
  logic [4:0]  nv_addr;
  logic [6:0]  nv_wdata;
  logic [17:0] line_out;
  logic [3:0]  od_drive_low;
  int          checks = 0;
  int          fail_count = 0;

  always #2.5 clk = ~clk;

  ilsm_far_model far (.pat(pat), .trig_pin_in(trig), .serial_rxd_pin(rxd),
    .serial2_rxd_pin(rxd2), .serial1_tx_src(tx1), .serial2_tx_src(tx2), .pulse_gen_out(pg),
    .seq_duty_out(duty), .seq_pulse(sp), .seq_mask_pulse(smp), .seq_running(sr),
    .debounce_out(deb), .prescale_out(pre), .exposing(expo), .reading_out(rd),
    .trigger_feedback(tfb));

  io_line_switch_matrix dut (.clk(clk), .rst(rst), .trig_pin_in(trig), .serial_rxd_pin(rxd),
    .serial2_rxd_pin(rxd2), .serial1_tx_src(tx1), .serial2_tx_src(tx2), .pulse_gen_out(pg),
    .seq_duty_out(duty), .seq_pulse(sp), .seq_mask_pulse(smp), .seq_running(sr),
    .debounce_out(deb), .prescale_out(pre), .exposing(expo), .reading_out(rd),
    .trigger_feedback(tfb), .cfg_we(cfg_we), .cfg_line(cfg_line), .cfg_src(cfg_src),
    .cfg_inv(cfg_inv), .cfg_force_hi(cfg_fh), .cfg_op_we(cfg_op_we), .cfg_op(cfg_op),
    .save_req(save_req), .factory_req(factory_req), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_busy(nv_busy), .line_out(line_out),
    .od_drive_low(od_drive_low), .logic_result(logic_result));

  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  task automatic cfg(input int l, input int s, input logic i, input logic f);
    @(posedge clk);
    cfg_we   <= 1'b1;
    cfg_line <= 5'(l);
    cfg_src  <= 5'(s);
    cfg_inv  <= i;
    cfg_fh   <= f;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask : cfg

  // Covers the input synchroniser plus the registered cell and output stages.
  task automatic settle;
    repeat (10) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_route;
    int l;
    for (int s = 0; s < 25; s++)
      if (s != 19)
      begin
        l = s % 18;
        cfg(l, s, 1'b0, 1'b0);
        pat <= 25'h1 << s;
        settle;
        chk(line_out[l], 1'b1, "routed source high");
        if (l < 4) chk(od_drive_low[l], 1'b0, "open drain released");
        @(posedge clk);
        pat <= ~(25'h1 << s);
        settle;
        chk(line_out[l], 1'b0, "routed source low");
        if (l < 4) chk(od_drive_low[l], 1'b1, "open drain pulled");
      end
    cfg(6, 0, 1'b0, 1'b0);
    pat <= 25'h1;
    settle;
    chk(line_out[6], 1'b1, "pin on trigger line high");
    @(posedge clk);
    pat <= 25'h0;
    settle;
    chk(line_out[6], 1'b0, "pin on trigger line low");
    $display("test route done");
  endtask : t_route

  task automatic mod_case(input logic i, input logic f, input int s, input logic b,
                          input logic e);
    cfg(2, s, i, f);
    pat <= {24'h0, b};
    settle;
    chk(line_out[2], e, "line modifier");
  endtask : mod_case

  task automatic t_mods;
    mod_case(1'b1, 1'b0, 0, 1'b0, 1'b1);
    mod_case(1'b0, 1'b1, 0, 1'b0, 1'b1);
    mod_case(1'b1, 1'b1, 0, 1'b1, 1'b0);
    mod_case(1'b0, 1'b0, 31, 1'b1, 1'b0);
    mod_case(1'b0, 1'b0, 25, 1'b1, 1'b0);
    $display("test modifiers done");
  endtask : t_mods

  task automatic t_logic;
    logic a, b, e;
    cfg(10, 0, 1'b0, 1'b0);
    cfg(11, 1, 1'b0, 1'b0);
    cfg(6, 19, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      cfg_op_we <= 1'b1;
      cfg_op    <= ilsm_op_t'(k[1:0]);
      @(posedge clk);
      cfg_op_we <= 1'b0;
      for (int v = 0; v < 4; v++)
      begin
        a = v[0];
        b = v[1];
        e = (k == 0) ? (a & b) : (k == 1) ? (a | b) : (k == 2) ? (a ^ b) : ~(a & b);
        pat <= {23'h0, b, a};
        settle;
        chk(logic_result, e, "combiner result");
        chk(line_out[6], e, "combiner as source");
        @(posedge clk);
      end
    end
    $display("test combiner done");
  endtask : t_logic

  task automatic t_factory;
    @(posedge clk);
    factory_req <= 1'b1;
    @(posedge clk);
    factory_req <= 1'b0;
    pat         <= '1;
    cfg(20, 0, 1'b1, 1'b1);
    settle;
    chk(line_out, 18'h0, "defaults unrouted");
    $display("test factory done");
  endtask : t_factory

  task automatic t_save;
    int n;
    n = 0;
    cfg(2, 5, 1'b1, 1'b0);
    @(posedge clk);
    save_req <= 1'b1;
    @(posedge clk);
    save_req <= 1'b0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      if (nv_we === 1'b1)
      begin
        chk(18'(nv_addr), 18'(n), "save address");
        chk(18'(nv_wdata), (n == 2) ? 18'h25 : 18'h1f, "save word");
        n++;
      end
    end
    chk(18'(n), 18'h12, "save word count");
    chk(nv_busy, 1'b0, "save finished");
    $display("test save done");
  endtask : t_save

  task automatic print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_route;
    t_mods;
    t_logic;
    t_factory;
    t_save;
    print_verdict;
  end

  // The tests need under 3000 cycles; this cuts a hang well beyond that.
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict;
  end
endmodule : io_line_switch_matrix_tb_top
`default_nettype wire
